// >>> rtl/fsc_params.svh
// Constants of the flame safety time and switch check block.
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// System clock rate and the derived cycle count per millisecond.
`define FSC_CLK_HZ 100000000
`define FSC_CYC_PER_MS (`FSC_CLK_HZ / 1000)

// Safety times and switch agreement grace time in milliseconds.
`define FSC_SAFE_T1_MS 1000
`define FSC_SAFE_T2_MS 2000
`define FSC_SAFE_T3_MS 3000
`define FSC_SAFE_T5_MS 5000
`define FSC_GRACE_MS 8000

// Register byte offsets.
`define FSC_REG_CTRL 8'h00
`define FSC_REG_STATUS 8'h04
`define FSC_REG_ADDR 8'h08

// Control register fields and reset value.
`define FSC_CTRL_ENABLE 0
`define FSC_CTRL_CLEAR 1
`define FSC_CTRL_RESET 1'b1

// Status register fields.
`define FSC_ST_FLAME 0
`define FSC_ST_SWERR 1
`define FSC_ST_SHUT 2
`define FSC_ST_FLAME_IN 3
`define FSC_ST_SEL_LO 4
`define FSC_ST_SEL_HI 5

// Safety time selection positions within the mode switch.
`define FSC_SEL_POS1 0
`define FSC_SEL_POS2 1

// Lowest Modbus slave address set by the address switch.
`define FSC_ADDR_BASE 7'h01

`endif

// >>> rtl/fsc_pkg.sv
// Types shared by the flame safety time and switch check modules.
package fsc_pkg;

  // Supervisor state: flame indicated, flame absent, or locked in error.
  typedef enum logic [1:0] {
    FSC_OFF,
    FSC_ON,
    FSC_SHUT
  } fsc_state_t;

  // Safety time selection from positions 1 and 2 of the mode switch.
  typedef logic [1:0] fsc_sel_t;

endpackage : fsc_pkg

// >>> rtl/fsc_timer.sv
// Interval timer: counts while run is high, flags when the limit is reached.
`timescale 1ns/1ps
`default_nettype none

module fsc_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  fsc_tmr_if.tmr t
);

  logic [31:0] cnt_q;
  logic exp_q;
  wire at_end = (cnt_q == t.limit - 32'h1);

  ////////////////////////////////////////////////////////////////////////////
  // A drop of run clears the count, so only an unbroken interval expires.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
      exp_q <= 1'b0;
    end else if (ce_i) begin
      if (!t.run) begin
        cnt_q <= 32'h0;
        exp_q <= 1'b0;
      end else if (at_end) begin
        exp_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign t.expired = exp_q;
  assign t.count = cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the counting behaviour.
  timer_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !t.run |=> cnt_q == 32'h0 && !exp_q)
    else $error("timer did not restart after run dropped");

  timer_expiry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(exp_q) |-> $past(cnt_q) == t.limit - 32'h1 && $past(t.run))
    else $error("timer expired at the wrong count");

endmodule : fsc_timer

`default_nettype wire

// >>> rtl/fsc_tmr_if.sv
// Interface joining the supervisor to one interval timer.
`timescale 1ns/1ps
`default_nettype none

interface fsc_tmr_if;
  logic run;
  logic [31:0] limit;
  logic expired;
  logic [31:0] count;

  modport ctl (output run, output limit, input expired, input count);
  modport tmr (input run, input limit, output expired, output count);
endinterface : fsc_tmr_if

`default_nettype wire

// >>> rtl/fsc_top.sv
// Flame supervisor: safety time, relay, switch agreement check and Wishbone registers.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"

module fsc_top #(
  parameter int unsigned SAFE_T1_CYC = `FSC_SAFE_T1_MS * `FSC_CYC_PER_MS,
  parameter int unsigned SAFE_T2_CYC = `FSC_SAFE_T2_MS * `FSC_CYC_PER_MS,
  parameter int unsigned SAFE_T3_CYC = `FSC_SAFE_T3_MS * `FSC_CYC_PER_MS,
  parameter int unsigned SAFE_T5_CYC = `FSC_SAFE_T5_MS * `FSC_CYC_PER_MS,
  parameter int unsigned GRACE_CYC = `FSC_GRACE_MS * `FSC_CYC_PER_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic flame_sig_i,
  input wire logic [5:0] bus_address_switch_i,
  input wire logic [7:0] mode_switch_chan_one_i,
  input wire logic [7:0] mode_switch_chan_two_i,
  output logic flame_relay_o,
  output logic flame_led_green_o,
  output logic switch_err_led_o,
  output logic error_shutdown_o,
  output logic [6:0] modbus_addr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Safety time decode, used for the timer limit and its check.
  function automatic logic [31:0] fsc_safe_cyc(input fsc_pkg::fsc_sel_t sel);
    logic [31:0] r;
    r = 32'(SAFE_T1_CYC);
    unique case (sel)
      2'h0: r = 32'(SAFE_T1_CYC);
      2'h1: r = 32'(SAFE_T2_CYC);
      2'h2: r = 32'(SAFE_T3_CYC);
      2'h3: r = 32'(SAFE_T5_CYC);
    endcase
    return r;
  endfunction : fsc_safe_cyc

  fsc_pkg::fsc_state_t st_q;
  fsc_pkg::fsc_state_t st_d;
  logic enable_q;
  logic clear_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic relay_q;
  logic green_q;
  logic swerr_q;
  logic shut_q;
  logic [6:0] addr_q;

  fsc_tmr_if safe_t ();
  fsc_tmr_if grace_t ();

  ////////////////////////////////////////////////////////////////////////////
  // Switch decode. The safety time follows channel one; a disagreement with
  // channel two that lasts GRACE_CYC is caught by the grace timer and ends in shutdown.
  wire mismatch = (mode_switch_chan_one_i != mode_switch_chan_two_i);
  wire fsc_pkg::fsc_sel_t sel = {mode_switch_chan_one_i[`FSC_SEL_POS2], mode_switch_chan_one_i[`FSC_SEL_POS1]};
  wire [6:0] addr_d = {1'b0, bus_address_switch_i} + `FSC_ADDR_BASE;

  // Timer steering: safety count runs only during an outage while flame is
  // indicated; grace count runs only while the copies differ.
  assign safe_t.run = (st_q == fsc_pkg::FSC_ON) && !flame_sig_i;
  assign safe_t.limit = fsc_safe_cyc(sel);
  assign grace_t.run = mismatch;
  assign grace_t.limit = 32'(GRACE_CYC);

  fsc_timer u_safe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .t(safe_t.tmr)
  );

  fsc_timer u_grace (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .t(grace_t.tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode. Writes land on the edge where the master sees ack.
  wire req = wb_cyc_i && wb_stb_i;
  wire wr_ctrl = req && wb_we_i && ack_q && wb_sel_i[0] && (wb_adr_i == `FSC_REG_CTRL);
  wire clr_req = wr_ctrl && wb_dat_i[`FSC_CTRL_CLEAR];
  wire [31:0] status_w = {26'h0, sel, flame_sig_i, shut_q, swerr_q, relay_q};
  wire [31:0] ctrl_w = {31'h0, enable_q};
  wire [31:0] rd_mux = (wb_adr_i == `FSC_REG_CTRL) ? ctrl_w :
                       (wb_adr_i == `FSC_REG_STATUS) ? status_w :
                       (wb_adr_i == `FSC_REG_ADDR) ? {25'h0, addr_q} : 32'h0;

  // Shutdown is latched; a clear request is honoured only if the copies
  // agree, and a grace expiry in the same cycle wins over the clear.
  wire shut_set = grace_t.expired;
  wire shut_next = shut_set || (shut_q && !clear_q);

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor next state.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      fsc_pkg::FSC_OFF: begin
        if (shut_next) begin
          st_d = fsc_pkg::FSC_SHUT;
        end else if (enable_q && flame_sig_i) begin
          st_d = fsc_pkg::FSC_ON;
        end
      end
      fsc_pkg::FSC_ON: begin
        if (shut_next) begin
          st_d = fsc_pkg::FSC_SHUT;
        end else if (!enable_q || safe_t.expired) begin
          st_d = fsc_pkg::FSC_OFF;
        end
      end
      fsc_pkg::FSC_SHUT: begin
        if (!shut_next) begin
          st_d = fsc_pkg::FSC_OFF;
        end
      end
      default: st_d = fsc_pkg::FSC_SHUT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, indicators and relay. Lamp and relay share one source.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= fsc_pkg::FSC_OFF;
      relay_q <= 1'b0;
      green_q <= 1'b0;
      swerr_q <= 1'b0;
      shut_q <= 1'b0;
      addr_q <= `FSC_ADDR_BASE;
    end else if (ce_i) begin
      st_q <= st_d;
      relay_q <= (st_d == fsc_pkg::FSC_ON);
      green_q <= (st_d == fsc_pkg::FSC_ON);
      swerr_q <= mismatch;
      shut_q <= shut_next;
      addr_q <= addr_d;
    end
  end

  // Register bus. Ack is one cycle; a clear request is held for one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= `FSC_CTRL_RESET;
      clear_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else if (ce_i) begin
      ack_q <= req && !ack_q;
      rdat_q <= (req && !ack_q) ? rd_mux : 32'h0;
      clear_q <= clr_req && !mismatch;
      if (wr_ctrl) begin
        enable_q <= wb_dat_i[`FSC_CTRL_ENABLE];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign flame_relay_o = relay_q;
  assign flame_led_green_o = green_q;
  assign switch_err_led_o = swerr_q;
  assign error_shutdown_o = shut_q;
  assign modbus_addr_o = addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the supervisor.
  addr_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> modbus_addr_o >= 7'h01 && modbus_addr_o <= 7'h40)
    else $error("modbus address out of range");

  relay_opens_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_q == fsc_pkg::FSC_ON && safe_t.expired && !shut_next |=> !flame_relay_o)
    else $error("relay stayed closed after the safety time");

  default_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_switch_chan_one_i[1:0] == 2'h0 |-> safe_t.limit == 32'(SAFE_T1_CYC))
    else $error("default safety time not selected");

  five_sec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_switch_chan_one_i[1:0] == 2'h3 |-> safe_t.limit == 32'(SAFE_T5_CYC))
    else $error("both positions on did not give the longest time");

  grace_shut_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(error_shutdown_o) |-> $past(grace_t.count) == 32'(GRACE_CYC) - 32'h1)
    else $error("shutdown before the grace time ran out");

  shut_relay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    error_shutdown_o |-> !flame_relay_o)
    else $error("relay closed during error shutdown");

  lamp_relay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flame_led_green_o == flame_relay_o)
    else $error("flame lamp and relay disagree");

  swerr_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mismatch |=> switch_err_led_o)
    else $error("switch error lamp late");

  flame_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && flame_relay_o && flame_sig_i && enable_q && !shut_next |=> flame_relay_o)
    else $error("relay opened while flame present");

endmodule : fsc_top

`default_nettype wire

// >>> verif/fsc_burner_model.sv
// Burner control model that watches the flame relay and counts its openings.
`timescale 1ns/1ps
`default_nettype none

module fsc_burner_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic relay_i,
  output logic [7:0] open_cnt_o
);
  logic relay_q;

  ////////////////////////////////////////////////////////////////////////////
  // Each falling relay contact is one flame-off report to the burner control.
  always_ff @(posedge clk_i) begin
    relay_q <= relay_i;
    if (rst_i) begin
      open_cnt_o <= 8'h00;
    end else if (relay_q && !relay_i) begin
      open_cnt_o <= open_cnt_o + 8'h01;
    end
  end
endmodule : fsc_burner_model

`default_nettype wire

// >>> verif/tb_flame_safety_time_and_switch_check.sv
// Testbench of the flame supervisor, driving flame, switches and the Wishbone port.
`timescale 1ns/1ps
`default_nettype none

module tb_flame_safety_time_and_switch_check;
  localparam int T[4] = '{10, 20, 30, 50};
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, flame = 0, relay, green, red, shut, ack;
  logic ce = 1'b1;
  logic [3:0] bsel = 4'hf;
  logic [7:0] adr = 8'h00, m1 = 8'h00, m2 = 8'h00, opens;
  logic [31:0] wdat = 32'h0, rdat, d;
  logic [5:0] asw = 6'h00;
  logic [6:0] maddr;
  int num_errors = 0, checks_done = 0;

  fsc_top #(.SAFE_T1_CYC(10), .SAFE_T2_CYC(20), .SAFE_T3_CYC(30), .SAFE_T5_CYC(50), .GRACE_CYC(80)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .flame_sig_i(flame), .bus_address_switch_i(asw), .mode_switch_chan_one_i(m1),
    .mode_switch_chan_two_i(m2), .flame_relay_o(relay), .flame_led_green_o(green),
    .switch_err_led_o(red), .error_shutdown_o(shut), .modbus_addr_o(maddr));

  fsc_burner_model burner (.clk_i(clk_i), .rst_i(rst_i), .relay_i(relay), .open_cnt_o(opens));

  ////////////////////////////////////////////////////////////////////////////
  // A 10 ns system clock.
  always #5 clk_i = ~clk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One classic cycle; the request stands until ack is sampled, never a fixed wait.
  // A slave that never answers is caught by the watchdog, not by a local limit.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
                    output logic [31:0] rd);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= wd; bsel <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic finish_test;
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard: the tests need well under 2000 cycles.
  initial begin
    tick(6000);
    num_errors++;
    finish_test();
  end

  // Main sequence.
  initial begin
    tick(8);
    rst_i <= 1'b0;
    tick(2);
    chk(maddr, 7'h01);
    chk(relay, 1'b0);
    // Every switch setting maps to address value plus one.
    for (int v = 0; v < 64; v++) begin
      asw <= v[5:0];
      tick(3);
      chk(maddr, v[6:0] + 7'h01);
    end
    wb(1'b0, 8'h08, 32'h0, 4'hf, d);
    chk(d, 32'h40);
    wb(1'b0, 8'h0c, 32'h0, 4'hf, d);
    chk(d, 32'h0);
    // Each safety time selection: relay holds N cycles of outage, then opens.
    for (int s = 0; s < 4; s++) begin
      m1 <= s[7:0];
      m2 <= s[7:0];
      flame <= 1'b1;
      tick(3);
      chk({relay, green}, 2'b11);
      flame <= 1'b0;
      tick(T[s]);
      chk(relay, 1'b1);
      tick(4);
      chk({relay, green}, 2'b00);
    end
    chk(opens, 8'h04);
    // A brief return of the flame must restart the count from zero.
    m1 <= 8'h01;
    m2 <= 8'h01;
    flame <= 1'b1;
    tick(3);
    flame <= 1'b0;
    tick(18);
    flame <= 1'b1;
    tick(1);
    flame <= 1'b0;
    tick(18);
    chk(relay, 1'b1);
    tick(6);
    chk(relay, 1'b0);
    // A mismatch fixed within the grace time lights red but does not shut down.
    flame <= 1'b1;
    m2 <= 8'h05;
    tick(3);
    chk(red, 1'b1);
    tick(40);
    m2 <= 8'h01;
    tick(3);
    chk({red, shut, relay}, 3'b001);
    // A lasting mismatch shuts down and opens the relay despite flame.
    m2 <= 8'h09;
    tick(78);
    chk(shut, 1'b0);
    tick(8);
    chk({shut, relay, green}, 3'b100);
    wb(1'b0, 8'h04, 32'h0, 4'hf, d);
    chk(d[5:0], 6'h1e);
    // Clearing while switches agree releases the shutdown.
    m2 <= 8'h01;
    tick(3);
    wb(1'b1, 8'h00, 32'h3, 4'hf, d);
    tick(4);
    chk({shut, red, relay}, 3'b001);
    // A low clock enable freezes all state: no safety count, no address update.
    ce <= 1'b0;
    asw <= 6'h05;
    flame <= 1'b0;
    tick(30);
    chk({maddr, relay}, 8'h81);
    ce <= 1'b1;
    tick(3);
    chk(maddr, 7'h06);
    tick(16);
    chk(relay, 1'b1);
    tick(4);
    chk(relay, 1'b0);
    // Enable bit: a write without byte lane 0 is ignored, a full write drops the relay.
    flame <= 1'b1;
    tick(3);
    chk({relay, green}, 2'b11);
    wb(1'b1, 8'h00, 32'h0, 4'he, d);
    wb(1'b0, 8'h00, 32'h0, 4'hf, d);
    chk(d, 32'h1);
    chk(relay, 1'b1);
    wb(1'b1, 8'h00, 32'h0, 4'hf, d);
    tick(3);
    chk({relay, green}, 2'b00);
    wb(1'b0, 8'h00, 32'h0, 4'hf, d);
    chk(d, 32'h0);
    finish_test();
  end
endmodule : tb_flame_safety_time_and_switch_check

`default_nettype wire
